// *** design/irq_pending_clear_bank.sv ***
/*
 * pending-state bank for interrupt lines 0..63 with clear and force views,
 * an event status/mask pair and one level interrupt output.
 * assumes a single-cycle strobe bus on mclk, read data one cycle later,
 * and enable / in-service levels supplied by the rest of the controller.
 */
// The implementer's own choices: the address map and strobed register access.
`default_nettype none

module irq_pending_clear_bank
	import irq_pend_pkg::*;
#(
	parameter int unsigned N_IRQ = NUM_IRQ
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rdata_q,
	// interrupt lines from peripherals, one cycle high per event
	input wire logic [N_IRQ-1:0] irq_event,
	// per-line state from enable and active-state logic
	input wire logic [N_IRQ-1:0] irq_enabled,
	input wire logic [N_IRQ-1:0] irq_in_service,
	// pending state to the priority logic
	output logic [N_IRQ-1:0] pending_q,
	// block interrupt
	output logic irq_q
);

	// address decode
	logic hit_clear_low;
	logic hit_clear_mid;
	logic hit_force_low;
	logic hit_force_mid;
	logic hit_status;
	logic hit_mask;
	logic hit_any;

	always_comb begin
		hit_clear_low = 1'b0;
		hit_clear_mid = 1'b0;
		hit_force_low = 1'b0;
		hit_force_mid = 1'b0;
		hit_status = 1'b0;
		hit_mask = 1'b0;
		if (addr == OFS_PEND_CLEAR_LOW) begin
			hit_clear_low = 1'b1;
		end else if (addr == OFS_PEND_CLEAR_MID) begin
			hit_clear_mid = 1'b1;
		end else if (addr == OFS_PEND_FORCE_LOW) begin
			hit_force_low = 1'b1;
		end else if (addr == OFS_PEND_FORCE_MID) begin
			hit_force_mid = 1'b1;
		end else if (addr == OFS_EVENT_STATUS) begin
			hit_status = 1'b1;
		end else if (addr == OFS_EVENT_MASK) begin
			hit_mask = 1'b1;
		end
	end

	assign hit_any = hit_clear_low || hit_clear_mid || hit_force_low || hit_force_mid || hit_status || hit_mask;

	// per-line requests from software
	logic [N_IRQ-1:0] clear_vec;
	logic [N_IRQ-1:0] force_vec;
	logic [DATA_W-1:0] mid_wdata;

	// reserved bits dropped so a stray 1 there cannot reach lines 56/57
	assign mid_wdata = wdata & ~MID_RSV_MASK;

	always_comb begin
		clear_vec = '0;
		force_vec = '0;
		if (wr_en && hit_clear_low) begin
			clear_vec[31:0] = wdata;
		end
		if (wr_en && hit_clear_mid) begin
			clear_vec[63:32] = mid_wdata;
		end
		if (wr_en && hit_force_low) begin
			force_vec[31:0] = wdata;
		end
		if (wr_en && hit_force_mid) begin
			force_vec[63:32] = mid_wdata;
		end
	end

	// the flags themselves
	logic [N_IRQ-1:0] pend_now;
	logic [N_IRQ-1:0] refused_vec;

	genvar gi;
	generate
		for (gi = 0; gi < N_IRQ; gi++) begin : g_line
			pend_flag #(
				.IMPL(IRQ_IMPL[gi])
			) u_flag (
				.mclk(mclk),
				.rst_n(rst_n),
				.hw_set(irq_event[gi] && IRQ_IMPL[gi]),
				.force_set(force_vec[gi]),
				.clear_req(clear_vec[gi]),
				.enabled(irq_enabled[gi]),
				.in_service(irq_in_service[gi]),
				.pending(pend_now[gi]),
				.clear_refused(refused_vec[gi])
			);
		end
	endgenerate

	// mirrors the flags onto the output pins; one cycle behind pend_now
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= '0;
		end else begin
			pending_q <= pend_now;
		end
	end

	// events
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_status_q;
	logic [EV_W-1:0] ev_mask_q;
	logic [N_IRQ-1:0] pend_prev_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend_prev_q <= '0;
		end else begin
			pend_prev_q <= pend_now;
		end
	end

	always_comb begin
		ev_set = '0;
		ev_set[EV_CLEAR_REFUSED] = |refused_vec;
		ev_set[EV_RSV_WRITE] = wr_en && (hit_clear_mid || hit_force_mid) && |(wdata & MID_RSV_MASK);
		ev_set[EV_BAD_ADDR] = (wr_en || rd_en) && !hit_any;
		ev_set[EV_NEW_PENDING] = |(pend_now & ~pend_prev_q);
	end

	// write one clears; a new event in the same cycle keeps its bit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ev_status_q <= EV_STATUS_RST;
		end else if (wr_en && hit_status) begin
			ev_status_q <= (ev_status_q & ~wdata[EV_W-1:0]) | ev_set;
		end else begin
			ev_status_q <= ev_status_q | ev_set;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ev_mask_q <= EV_MASK_RST;
		end else if (wr_en && hit_mask) begin
			ev_mask_q <= wdata[EV_W-1:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(ev_status_q & ev_mask_q);
		end
	end

	// read path: data stand for exactly the cycle after the strobe
	logic [DATA_W-1:0] rd_value;

	always_comb begin
		rd_value = '0;
		if (hit_clear_low || hit_force_low) begin
			rd_value = pend_now[31:0];
		end else if (hit_clear_mid || hit_force_mid) begin
			rd_value = pend_now[63:32] & ~MID_RSV_MASK;
		end else if (hit_status) begin
			rd_value[EV_W-1:0] = ev_status_q;
		end else if (hit_mask) begin
			rd_value[EV_W-1:0] = ev_mask_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= RDATA_RST;
		end else if (rd_en) begin
			rdata_q <= rd_value;
		end else begin
			rdata_q <= RDATA_RST;
		end
	end

endmodule // irq_pending_clear_bank

`default_nettype wire

// *** design/pend_flag.sv ***
/*
 * one interrupt's pending flag, shared by the clear and force views.
 * assumes its requests are one-cycle strobes synchronous to mclk.
 */
`default_nettype none

module pend_flag
	import irq_pend_pkg::*;
#(
	parameter bit IMPL = 1'b1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// requests
	input wire logic hw_set,
	input wire logic force_set,
	input wire logic clear_req,
	// line state from the rest of the controller
	input wire logic enabled,
	input wire logic in_service,
	// state
	output logic pending,
	output logic clear_refused
);

	logic pend_q;
	logic pend_d;
	logic do_force;
	logic do_clear;

	assign do_force = force_set && enabled && !pend_q;
	assign do_clear = clear_req && !in_service;

	always_comb begin
		pend_d = pend_q;
		if (do_clear) begin
			pend_d = 1'b0;
		end
		// a set in the same cycle as a clear wins (a force only on an enabled, idle flag), so no event is lost
		if (hw_set || do_force) begin
			pend_d = 1'b1;
		end
		if (!IMPL) begin
			pend_d = PEND_RST;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= PEND_RST;
		end else begin
			pend_q <= pend_d;
		end
	end

	assign pending = pend_q;
	assign clear_refused = IMPL && clear_req && in_service && pend_q;

endmodule // pend_flag

`default_nettype wire

// *** shared/irq_pend_pkg.sv ***
/*
 * constants shared by the pending-flag bank and its cell: register offsets,
 * field positions, reset values and the map of implemented interrupt lines.
 * assumes a 32-bit software port with byte offsets on word boundaries.
 */
`default_nettype none

package irq_pend_pkg;

	localparam int unsigned NUM_IRQ = 64;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_PEND_CLEAR_LOW = 8'h00;
	localparam logic [7:0] OFS_PEND_CLEAR_MID = 8'h04;
	localparam logic [7:0] OFS_PEND_FORCE_LOW = 8'h08;
	localparam logic [7:0] OFS_PEND_FORCE_MID = 8'h0c;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h14;

	// lines 56 and 57 do not exist; their bits in the mid word are write-as-zero
	localparam logic [63:0] IRQ_IMPL = 64'hfcff_ffff_ffff_ffff;
	localparam logic [31:0] MID_RSV_MASK = 32'h0300_0000;

	// event status / mask layout
	localparam int unsigned EV_W = 4;
	localparam int unsigned EV_CLEAR_REFUSED = 0;
	localparam int unsigned EV_RSV_WRITE = 1;
	localparam int unsigned EV_BAD_ADDR = 2;
	localparam int unsigned EV_NEW_PENDING = 3;

	// values after reset
	localparam logic PEND_RST = 1'b0;
	localparam logic [EV_W-1:0] EV_STATUS_RST = 4'h0;
	localparam logic [EV_W-1:0] EV_MASK_RST = 4'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

endpackage : irq_pend_pkg

`default_nettype wire

// *** tb/pend_chk_assertions.sv ***
/*
 checker on the ports of the pending bank.
 assumes it is bound onto irq_pending_clear_bank with the same line count.
*/
`default_nettype none

module pend_chk
	import irq_pend_pkg::*;
#(
	parameter int unsigned N_IRQ = NUM_IRQ
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [DATA_W-1:0] rdata_q,
	// line state
	input wire logic [N_IRQ-1:0] irq_event,
	input wire logic [N_IRQ-1:0] irq_enabled,
	input wire logic [N_IRQ-1:0] irq_in_service,
	input wire logic [N_IRQ-1:0] pending_q,
	input wire logic irq_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// a same-cycle event would win, so it is excluded
	property p_clr(logic [7:0] a, int b, int n);
		wr_en && addr == a && wdata[b] && !irq_in_service[n] && !irq_event[n] |-> ##2 !pending_q[n];
	endproperty
	// pins lag the flag by one cycle: look one cycle on, then one more
	sequence s_was_pending(int n);
		##1 pending_q[n];
	endsequence
	sequence s_was_idle(int n);
		##1 !pending_q[n];
	endsequence
	a_rdata_idle: assert property (!$past(rd_en) |-> rdata_q == '0)
		else $error("read data outside slot");
	a_read_low: assert property (rd_en && addr == OFS_PEND_CLEAR_LOW |=> rdata_q == pending_q[31:0])
		else $error("low read");
	a_read_mid: assert property (rd_en && addr == OFS_PEND_FORCE_MID |=> rdata_q == pending_q[63:32])
		else $error("mid read");
	a_clr_low: assert property (p_clr(OFS_PEND_CLEAR_LOW, 5, 5)) else $error("low clear");
	a_clr_mid: assert property (p_clr(OFS_PEND_CLEAR_MID, 3, 35)) else $error("mid clear");
	a_clr_top: assert property (p_clr(OFS_PEND_CLEAR_MID, 31, 63)) else $error("top clear");
	a_service_keeps: assert property (wr_en && addr == OFS_PEND_CLEAR_LOW && irq_in_service[1] |-> s_was_pending(1) |=> pending_q[1])
		else $error("in-service line cleared");
	a_zero_keeps: assert property (wr_en && addr == OFS_PEND_CLEAR_LOW && !wdata[2] |-> s_was_pending(2) |=> pending_q[2])
		else $error("zero write cleared");
	a_force_sets: assert property (wr_en && addr == OFS_PEND_FORCE_LOW && wdata[4] && irq_enabled[4] |-> ##2 pending_q[4])
		else $error("force missed");
	a_force_off: assert property (wr_en && addr == OFS_PEND_FORCE_LOW && wdata[6] && !irq_enabled[6] && !irq_event[6]
		|-> s_was_idle(6) |=> !pending_q[6]) else $error("disabled line forced");
	a_unused_zero: assert property (pending_q[57:56] == 2'b00) else $error("unused line pending");
endmodule // pend_chk

bind irq_pending_clear_bank pend_chk #(.N_IRQ(N_IRQ)) u_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .irq_event(irq_event),
	.irq_enabled(irq_enabled), .irq_in_service(irq_in_service), .pending_q(pending_q), .irq_q(irq_q));

`default_nettype wire

// *** tb/test_irq_pending_clear_bank.sv ***
/*
 self-checking bench for the pending bank.
 assumes the checker file is compiled with it.
*/
`default_nettype none

module test_irq_pending_clear_bank import irq_pend_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0, rdata_q, d, w;
	logic wr_en = 1'b0, rd_en = 1'b0, irq_q;
	logic [63:0] irq_event = '0, irq_enabled = '0, irq_in_service = '0, pending_q, m, ev, en, ins;
	int seed = 32'hb29b;
	int miscompares = 0, checks_done = 0, cyc = 0;
	always #5 mclk = ~mclk;
	irq_pending_clear_bank uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata_q(rdata_q), .irq_event(irq_event), .irq_enabled(irq_enabled),
		.irq_in_service(irq_in_service), .pending_q(pending_q), .irq_q(irq_q));
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [63:0] e, input logic [63:0] s);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	// all signals move 1ns after the edge, one bus cycle per call
	task step(input logic wv, input logic rv, input logic [7:0] a, input logic [31:0] dv);
		wr_en <= wv;
		rd_en <= rv;
		addr <= a;
		wdata <= dv;
		@(posedge mclk);
		#1;
	endtask
	task rd(input logic [7:0] a);
		step(1'b0, 1'b1, a, '0);
		d = rdata_q;
	endtask
	function automatic logic [31:0] clr(input logic [31:0] f, input logic [31:0] v, input logic [31:0] s);
		return f & ~(v & ~s);
	endfunction
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1 rst_n <= 1'b1;
		chk("pending", '0, pending_q);
		m = '0;
		$display("test reset done");
		for (int i = 0; i < 30; i++) begin
			ev = {$random(seed), $random(seed)};
			en = {$random(seed), $random(seed)};
			ins = {$random(seed), $random(seed)};
			irq_event <= ev;
			irq_in_service <= ins;
			irq_enabled <= en;
			step(1'b0, 1'b0, '0, '0);
			irq_event <= '0;
			m = m | (ev & IRQ_IMPL);
			w = $random(seed);
			step(1'b1, 1'b0, OFS_PEND_FORCE_LOW, w);
			m[31:0] = m[31:0] | (w & en[31:0]);
			w = $random(seed);
			step(1'b1, 1'b0, OFS_PEND_FORCE_MID, w);
			m[63:32] = m[63:32] | (w & en[63:32] & ~MID_RSV_MASK);
			w = (i == 0) ? '1 : $random(seed);
			step(1'b1, 1'b0, OFS_PEND_CLEAR_LOW, w);
			m[31:0] = clr(m[31:0], w, ins[31:0]);
			w = (i == 1) ? '0 : $random(seed);
			step(1'b1, 1'b0, OFS_PEND_CLEAR_MID, w);
			m[63:32] = clr(m[63:32], w, ins[63:32]);
			rd(OFS_PEND_CLEAR_LOW);
			chk("low word", {32'h0, m[31:0]}, {32'h0, d});
			rd(OFS_PEND_FORCE_MID);
			chk("mid word", {32'h0, m[63:32]}, {32'h0, d});
			chk("pending", m, pending_q);
		end
		$display("test random done");
		step(1'b1, 1'b0, OFS_EVENT_STATUS, 32'hf);
		step(1'b1, 1'b0, OFS_EVENT_MASK, 32'h1 << EV_BAD_ADDR);
		step(1'b0, 1'b0, '0, '0);
		chk("irq idle", '0, {63'h0, irq_q});
		rd(8'h40);
		chk("unmapped read", '0, {32'h0, d});
		repeat (2) step(1'b0, 1'b0, '0, '0);
		chk("irq raised", 64'h1, {63'h0, irq_q});
		rd(OFS_EVENT_STATUS);
		chk("status", 64'h4, {32'h0, d});
		step(1'b1, 1'b0, OFS_EVENT_MASK, '0);
		repeat (2) step(1'b0, 1'b0, '0, '0);
		chk("irq masked", '0, {63'h0, irq_q});
		step(1'b1, 1'b0, OFS_EVENT_MASK, 32'h4);
		step(1'b1, 1'b0, OFS_EVENT_STATUS, 32'h4);
		repeat (2) step(1'b0, 1'b0, '0, '0);
		chk("irq cleared", '0, {63'h0, irq_q});
		// a stray 1 in the unused mid bits must be flagged and touch no line
		step(1'b1, 1'b0, OFS_EVENT_STATUS, 32'hf);
		step(1'b1, 1'b0, OFS_PEND_CLEAR_MID, MID_RSV_MASK);
		rd(OFS_EVENT_STATUS);
		chk("reserved write", 64'h2, {32'h0, d});
		chk("pending kept", m, pending_q);
		$display("test interrupt done");
		end_of_test();
	end
endmodule // test_irq_pending_clear_bank

`default_nettype wire
